// file: common/dms_pkg.sv
// Package for the module-status and channel diagnosis telegram builder.
// Assumes one 125 MHz clock and a 32-bit Avalon-MM register slave.
package dms_pkg;

    // Register byte offsets
    localparam logic [7:0] DMS_CTRL_OFS      = 8'h00;
    localparam logic [7:0] DMS_STATUS_OFS    = 8'h04;
    localparam logic [7:0] DMS_IRQ_STAT_OFS  = 8'h08;
    localparam logic [7:0] DMS_IRQ_MASK_OFS  = 8'h0C;
    localparam logic [7:0] DMS_MOD_STATE_OFS = 8'h10;
    localparam logic [7:0] DMS_CHAN_OFS      = 8'h20;

    // Control fields
    localparam int DMS_CTRL_START_BIT = 0;
    localparam int DMS_CTRL_HDR_LSB   = 8;

    // Status fields
    localparam int DMS_STAT_BUSY_BIT  = 0;
    localparam int DMS_STAT_CNT_LSB   = 8;

    // Interrupt bits
    localparam int DMS_IRQ_DONE_BIT   = 0;
    localparam int DMS_IRQ_DIAG_BIT   = 1;
    localparam int DMS_IRQ_W          = 2;

    // Channel entry register fields
    localparam int DMS_CE_MOD_LSB     = 0;
    localparam int DMS_CE_CH_LSB      = 8;
    localparam int DMS_CE_DIR_LSB     = 14;
    localparam int DMS_CE_WID_LSB     = 16;
    localparam int DMS_CE_CODE_LSB    = 24;
    localparam int DMS_CE_ACT_BIT     = 31;

    // Telegram layout
    localparam int         DMS_MOD_MAX      = 64;
    localparam int         DMS_STATE_BYTES  = 16;
    localparam logic [4:0] DMS_STATE_FIRST  = 5'h04;
    localparam logic [4:0] DMS_STATE_LAST   = 5'h13;
    localparam logic [7:0] DMS_STATUS_TYPE  = 8'h82;
    localparam logic [7:0] DMS_SLOT_NO      = 8'h00;
    localparam logic [7:0] DMS_SPECIFIER    = 8'h00;
    localparam logic [1:0] DMS_CHAN_MARK    = 2'h2;
    localparam logic [1:0] DMS_ENTRY_LAST   = 2'h2;
    localparam int         DMS_ENTRIES      = 8;

    // Reset values
    localparam logic [7:0] DMS_HDR_RST      = 8'h00;
    localparam logic [1:0] DMS_IRQ_MASK_RST = 2'h0;

    // Module states
    typedef enum logic [1:0] {
        DMS_MS_OK      = 2'h0,
        DMS_MS_DIAG    = 2'h1,
        DMS_MS_WRONG   = 2'h2,
        DMS_MS_MISSING = 2'h3
    } dms_mod_state_t;

    // Channel directions
    typedef enum logic [1:0] {
        DMS_DIR_IN    = 2'h1,
        DMS_DIR_OUT   = 2'h2,
        DMS_DIR_INOUT = 2'h3
    } dms_dir_t;

    // Data width classes
    typedef enum logic [2:0] {
        DMS_WID_BIT   = 3'h1,
        DMS_WID_2BIT  = 3'h2,
        DMS_WID_4BIT  = 3'h3,
        DMS_WID_WORD  = 3'h6,
        DMS_WID_DWORD = 3'h7
    } dms_width_t;

    // Builder states, Gray along IDLE-STAT-CHAN-DONE; the STAT to DONE skip flips both bits
    typedef enum logic [1:0] {
        DMS_IDLE = 2'b00,
        DMS_STAT = 2'b01,
        DMS_CHAN = 2'b11,
        DMS_DONE = 2'b10
    } dms_state_t;

endpackage

// file: src/dms_builder.sv
// Builder of the module-status block and channel diagnosis entries.
// Assumes an Avalon-MM master on core_clk and a byte sink with ready.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module dms_builder
    import dms_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Telegram byte stream
    output logic      [7:0]  tel_data,
    output logic             tel_valid,
    output logic             tel_sop,
    output logic             tel_last,
    input  wire logic        tel_ready,
    // Interrupt
    output logic             irq
);

    // Register state
    logic [7:0]             hdr_reg;
    logic [127:0]           mod_state_reg;
    logic [127:0]           snap_reg;
    logic [31:0]            chan_reg [DMS_ENTRIES];
    logic [DMS_IRQ_W-1:0]   irq_stat_reg;
    logic [DMS_IRQ_W-1:0]   irq_mask_reg;
    logic                   ack_reg;
    logic [3:0]             cnt_reg;

    // Builder state
    dms_state_t             state_reg;
    logic [4:0]             byte_reg;
    logic [1:0]             sub_reg;
    logic [2:0]             idx_reg;
    logic                   done_evt;
    logic                   diag_evt;

    // Bus decode, stream load and entry search
    logic                   acc;
    logic                   wr_go;
    logic                   start;
    logic                   load;
    logic [11:0]            keys;
    logic [DMS_ENTRIES-1:0] act;
    logic [DMS_ENTRIES*12-1:0] key_vec;
    logic [3:0]             first_f;
    logic [3:0]             next_f;

    // Byte-lane merge of a write
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction

    // Sort key of an entry: module then channel
    function automatic logic [11:0] entry_key(input logic [31:0] e);
        return {e[DMS_CE_MOD_LSB +: 6], e[DMS_CE_CH_LSB +: 6]};
    endfunction

    // Smallest active key above a bound; {found, index}
    function automatic logic [3:0] find_next(
        input logic [DMS_ENTRIES*12-1:0] kv,
        input logic [DMS_ENTRIES-1:0]    av,
        input logic                      any,
        input logic [11:0]               bound
    );
        logic        f;
        logic [2:0]  bi;
        logic [11:0] bk;
        f  = 1'b0;
        bi = 3'h0;
        bk = 12'hFFF;
        for (int i = 0; i < DMS_ENTRIES; i++)
        begin
            if (av[i] && (any || kv[i*12 +: 12] > bound)
                && (!f || kv[i*12 +: 12] < bk))
            begin
                f  = 1'b1;
                bi = 3'(i);
                bk = kv[i*12 +: 12];
            end
        end
        return {f, bi};
    endfunction

    // Status block byte by position
    function automatic logic [7:0] status_byte(
        input logic [4:0]   pos,
        input logic [7:0]   hdr,
        input logic [127:0] st
    );
        logic [7:0] b;
        unique case (pos)
            5'h00:   b = hdr;
            5'h01:   b = DMS_STATUS_TYPE;
            5'h02:   b = DMS_SLOT_NO;
            5'h03:   b = DMS_SPECIFIER;
            default: b = st[(pos - DMS_STATE_FIRST) * 8 +: 8];
        endcase
        return b;
    endfunction

    // Channel entry byte by position
    function automatic logic [7:0] entry_byte(
        input logic [31:0] e,
        input logic [1:0]  s
    );
        logic [7:0] b;
        unique case (s)
            2'h0:    b = {DMS_CHAN_MARK, e[DMS_CE_MOD_LSB +: 6]};
            2'h1:    b = {e[DMS_CE_DIR_LSB +: 2], e[DMS_CE_CH_LSB +: 6]};
            default: b = {e[DMS_CE_WID_LSB +: 3], e[DMS_CE_CODE_LSB +: 5]};
        endcase
        return b;
    endfunction

    // Entry table in packed form
    always_comb
    begin
        key_vec = '0;
        act     = '0;
        for (int i = 0; i < DMS_ENTRIES; i++)
        begin
            key_vec[i*12 +: 12] = entry_key(chan_reg[i]);
            act[i]              = chan_reg[i][DMS_CE_ACT_BIT];
        end
    end

    assign keys    = entry_key(chan_reg[idx_reg]);
    assign first_f = find_next(key_vec, act, 1'b1, 12'h000);
    assign next_f  = find_next(key_vec, act, 1'b0, keys);

    // Bus handshake: one wait cycle per access
    assign acc             = (avs_read | avs_write) & ~ack_reg;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_go           = avs_write & ack_reg;
    assign start           = wr_go && avs_address == DMS_CTRL_OFS
                             && avs_byteenable[0]
                             && avs_writedata[DMS_CTRL_START_BIT]
                             && state_reg == DMS_IDLE;
    assign load            = ~tel_valid | tel_ready;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ack_reg <= 1'b0;
        else
            ack_reg <= acc;
    end

    // Read data
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (acc && avs_read)
        begin
            avs_readdata <= 32'h0000_0000;
            if (avs_address == DMS_CTRL_OFS)
                avs_readdata[DMS_CTRL_HDR_LSB +: 8] <= hdr_reg;
            else if (avs_address == DMS_STATUS_OFS)
            begin
                avs_readdata[DMS_STAT_BUSY_BIT]    <= state_reg != DMS_IDLE;
                avs_readdata[DMS_STAT_CNT_LSB +: 4] <= cnt_reg;
            end
            else if (avs_address == DMS_IRQ_STAT_OFS)
                avs_readdata[DMS_IRQ_W-1:0] <= irq_stat_reg;
            else if (avs_address == DMS_IRQ_MASK_OFS)
                avs_readdata[DMS_IRQ_W-1:0] <= irq_mask_reg;
            else if (avs_address >= DMS_MOD_STATE_OFS && avs_address < DMS_CHAN_OFS)
                avs_readdata <= mod_state_reg[avs_address[3:2] * 32 +: 32];
            else if (avs_address >= DMS_CHAN_OFS
                     && avs_address < DMS_CHAN_OFS + 8'(DMS_ENTRIES * 4))
                avs_readdata <= chan_reg[avs_address[4:2]];
        end
    end

    // Control and mask registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            hdr_reg      <= DMS_HDR_RST;
            irq_mask_reg <= DMS_IRQ_MASK_RST;
        end
        else if (wr_go)
        begin
            if (avs_address == DMS_CTRL_OFS && avs_byteenable[1])
                hdr_reg <= avs_writedata[DMS_CTRL_HDR_LSB +: 8];
            if (avs_address == DMS_IRQ_MASK_OFS && avs_byteenable[0])
                irq_mask_reg <= avs_writedata[DMS_IRQ_W-1:0];
        end
    end

    // Module state words, 64 modules of two bits
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            mod_state_reg <= '0;
        else if (wr_go && avs_address >= DMS_MOD_STATE_OFS
                 && avs_address < DMS_CHAN_OFS)
            mod_state_reg[avs_address[3:2] * 32 +: 32] <=
                be_merge(mod_state_reg[avs_address[3:2] * 32 +: 32],
                         avs_writedata, avs_byteenable);
    end

    // Channel entry table
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < DMS_ENTRIES; i++)
                chan_reg[i] <= 32'h0000_0000;
        end
        else if (wr_go && avs_address >= DMS_CHAN_OFS
                 && avs_address < DMS_CHAN_OFS + 8'(DMS_ENTRIES * 4))
            chan_reg[avs_address[4:2]] <=
                be_merge(chan_reg[avs_address[4:2]], avs_writedata, avs_byteenable);
    end

    // Sticky interrupt status, set wins over clear
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            irq_stat_reg <= '0;
        else
        begin
            logic [DMS_IRQ_W-1:0] clr;
            clr = '0;
            if (wr_go && avs_address == DMS_IRQ_STAT_OFS && avs_byteenable[0])
                clr = avs_writedata[DMS_IRQ_W-1:0];
            irq_stat_reg <= (irq_stat_reg & ~clr)
                            | {diag_evt, done_evt};
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Diagnosis present at frame start
    assign diag_evt = start && ((|mod_state_reg) || (|act));

    // Frame builder
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= DMS_IDLE;
            byte_reg  <= 5'h00;
            sub_reg   <= 2'h0;
            idx_reg   <= 3'h0;
            snap_reg  <= '0;
            cnt_reg   <= 4'h0;
            tel_data  <= 8'h00;
            tel_valid <= 1'b0;
            tel_sop   <= 1'b0;
            tel_last  <= 1'b0;
            done_evt  <= 1'b0;
        end
        else
        begin
            done_evt <= 1'b0;
            unique case (state_reg)
                DMS_IDLE:
                begin
                    if (start)
                    begin
                        snap_reg  <= mod_state_reg;
                        byte_reg  <= 5'h00;
                        cnt_reg   <= 4'h0;
                        state_reg <= DMS_STAT;
                    end
                end
                DMS_STAT:
                begin
                    if (load)
                    begin
                        tel_data  <= status_byte(byte_reg, hdr_reg, snap_reg);
                        tel_valid <= 1'b1;
                        tel_sop   <= byte_reg == 5'h00;
                        if (byte_reg == DMS_STATE_LAST)
                        begin
                            tel_last <= ~first_f[3];
                            if (first_f[3])
                            begin
                                idx_reg   <= first_f[2:0];
                                sub_reg   <= 2'h0;
                                state_reg <= DMS_CHAN;
                            end
                            else
                                state_reg <= DMS_DONE;
                        end
                        else
                            byte_reg <= byte_reg + 5'h01;
                    end
                end
                DMS_CHAN:
                begin
                    if (load)
                    begin
                        tel_data <= entry_byte(chan_reg[idx_reg], sub_reg);
                        tel_sop  <= 1'b0;
                        if (sub_reg == DMS_ENTRY_LAST)
                        begin
                            cnt_reg  <= cnt_reg + 4'h1;
                            tel_last <= ~next_f[3];
                            if (next_f[3])
                            begin
                                idx_reg <= next_f[2:0];
                                sub_reg <= 2'h0;
                            end
                            else
                                state_reg <= DMS_DONE;
                        end
                        else
                            sub_reg <= sub_reg + 2'h1;
                    end
                end
                DMS_DONE:
                begin
                    if (tel_ready)
                    begin
                        tel_valid <= 1'b0;
                        tel_sop   <= 1'b0;
                        tel_last  <= 1'b0;
                        done_evt  <= 1'b1;
                        state_reg <= DMS_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// file: tb/dms_sink.sv
// Telegram sink standing in for the fieldbus master.
// Assumes the builder's byte stream on core_clk; slow halves its pace.
`timescale 1ns/100ps
`default_nettype none

module dms_sink (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Telegram stream
    input  wire logic [7:0] tel_data,
    input  wire logic       tel_valid,
    input  wire logic       tel_sop,
    input  wire logic       tel_last,
    output logic            tel_ready,
    // Pace
    input  wire logic       slow
);
    logic [9:0] got [$];
    int         frames;

    // Collects flags and byte of each accepted transfer
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tel_ready <= 1'b0;
            frames    <= 0;
        end
        else
        begin
            tel_ready <= slow ? ~tel_ready : 1'b1;
            if (tel_valid && tel_ready)
            begin
                got.push_back({tel_last, tel_sop, tel_data});
                if (tel_last)
                    frames <= frames + 1;
            end
        end
    end
endmodule

`default_nettype wire

// file: tb/dms_builder_sva.sv
// Checker on the builder's ports.
// Assumes it is bound to every dms_builder instance.
`timescale 1ns/100ps
`default_nettype none

module dms_builder_sva (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // Avalon-MM slave
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Telegram stream
    input wire logic [7:0]  tel_data,
    input wire logic        tel_valid,
    input wire logic        tel_sop,
    input wire logic        tel_last,
    input wire logic        tel_ready,
    // Interrupt
    input wire logic        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [5:0] idx;
    logic [5:0] ent;
    logic [1:0] ph;

    // Byte position within the frame
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            idx <= 6'h00;
        else if (tel_valid && tel_ready)
            idx <= tel_last ? 6'h00 : idx + 6'h01;
    assign ent = idx - 6'h14;
    assign ph  = 2'(ent % 6'h03);

    valid_hold_a: assert property (tel_valid && !tel_ready |=> tel_valid
        && $stable(tel_data) && $stable({tel_sop, tel_last})) else $error("byte not held");
    wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait without request");
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait on first cycle");
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("wait longer than one cycle");
    sop_start_a: assert property (tel_valid |-> tel_sop == (idx == 6'h00))
        else $error("start flag misplaced");
    type_byte_a: assert property (tel_valid && idx == 6'h01 |-> tel_data == 8'h82)
        else $error("status type wrong");
    slot_byte_a: assert property (tel_valid && idx == 6'h02 |-> tel_data == 8'h00)
        else $error("slot number not zero");
    entry_mark_a: assert property (tel_valid && idx >= 6'h14 && ph == 2'h0
        |-> tel_data[7:6] == 2'h2) else $error("entry mark wrong");
    dir_byte_a: assert property (tel_valid && idx >= 6'h14 && ph == 2'h1
        |-> tel_data[7:6] != 2'h0) else $error("direction missing");
    last_pos_a: assert property (tel_valid && tel_last |-> idx >= 6'h13
        && (idx == 6'h13 || ph == 2'h2)) else $error("frame ends mid unit");

    cover property (tel_valid && tel_ready && tel_last);
    cover property (tel_valid && !tel_ready);
    cover property (avs_read && !avs_waitrequest);
    cover property (irq);
endmodule

bind dms_builder dms_builder_sva chk_u (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tel_data(tel_data),
    .tel_valid(tel_valid), .tel_sop(tel_sop), .tel_last(tel_last), .tel_ready(tel_ready),
    .irq(irq));

`default_nettype wire

// file: tb/test_dms_builder.sv
// Self-checking bench for the telegram builder.
// Assumes dms_sink on the stream and the checker bound to the design.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end

module test_dms_builder;
    import dms_pkg::*;

    logic        core_clk;
    logic        rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  tel_data;
    logic        tel_valid;
    logic        tel_sop;
    logic        tel_last;
    logic        tel_ready;
    logic        irq;
    logic        slow;
    logic [9:0]  exp_q [$];
    logic [31:0] q;
    int          miscompares;
    int          tests_run;

    dms_builder dut_u (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tel_data(tel_data), .tel_valid(tel_valid),
        .tel_sop(tel_sop), .tel_last(tel_last), .tel_ready(tel_ready), .irq(irq));
    dms_sink snk_u (.core_clk(core_clk), .rst(rst), .tel_data(tel_data),
        .tel_valid(tel_valid), .tel_sop(tel_sop), .tel_last(tel_last),
        .tel_ready(tel_ready), .slow(slow));

    task automatic tally_and_finish;
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic timeout;
        miscompares++;
        tally_and_finish();
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic w;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do
        begin
            @(posedge core_clk);
            w = avs_waitrequest;
            q = avs_readdata;
            n++;
            if (n > 50)
                timeout();
        end while (w);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic put4(input logic [7:0] hdr);
        exp_q = {};
        exp_q.push_back({2'h1, hdr});
        exp_q.push_back({2'h0, 8'h82});
        exp_q.push_back({2'h0, 8'h00});
        exp_q.push_back({2'h0, 8'h00});
    endtask

    // Waits for the next frame and compares it whole
    task automatic check_frame(input int f0);
        int n;
        n = 0;
        exp_q[$][9] = 1'b1;
        while (snk_u.frames == f0)
        begin
            @(negedge core_clk);
            n++;
            if (n > 2000)
                timeout();
        end
        `CHK("frame length", exp_q.size(), snk_u.got.size())
        foreach (exp_q[i])
            `CHK("frame byte", exp_q[i], snk_u.got[i])
        snk_u.got.delete();
    endtask

    task automatic test_regs;
        bus(1'b0, DMS_CTRL_OFS, 32'h0);
        `CHK("ctrl reset", 32'h0, q)
        bus(1'b0, DMS_IRQ_MASK_OFS, 32'h0);
        `CHK("mask reset", 32'h0, q)
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        bus(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, q)
    endtask

    task automatic test_full_frame;
        logic [31:0] sw [4];
        logic [2:0]  wt [5];
        logic [5:0]  m;
        logic [5:0]  c;
        int          f0;
        sw = '{32'h0000E41B, 32'h55AA0000, 32'h00000000, 32'hC0000003};
        wt = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
        for (int k = 0; k < 4; k++)
            bus(1'b1, DMS_MOD_STATE_OFS + 8'(4 * k), sw[k]);
        for (int i = 0; i < 8; i++)
        begin
            m = (i < 2) ? 6'h3F : 6'(20 - i);
            c = 6'(63 - i);
            bus(1'b1, DMS_CHAN_OFS + 8'(4 * i), (i < 5) ? {1'b1, 2'h0, 5'(i * 7 + 3), 5'h0,
                wt[i], 2'(i % 3 + 1), c, 2'h0, m} : 32'h00000001);
        end
        slow <= 1'b1;
        put4(8'h54);
        for (int j = 0; j < 16; j++)
            exp_q.push_back({2'h0, sw[j / 4][8 * (j % 4) +: 8]});
        for (int i = 4; i >= 0; i--)
        begin
            exp_q.push_back({4'h2, (i < 2) ? 6'h3F : 6'(20 - i)});
            exp_q.push_back({2'h0, 2'(i % 3 + 1), 6'(63 - i)});
            exp_q.push_back({2'h0, wt[i], 5'(i * 7 + 3)});
        end
        f0 = snk_u.frames;
        bus(1'b1, DMS_CTRL_OFS, 32'h00005401);
        check_frame(f0);
        bus(1'b0, DMS_STATUS_OFS, 32'h0);
        `CHK("entries", 4'h5, q[11:8])
        bus(1'b0, DMS_IRQ_STAT_OFS, 32'h0);
        `CHK("irq stat", 32'h3, q)
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, DMS_IRQ_MASK_OFS, 32'h1);
        `CHK("irq raised", 1'b1, irq)
        bus(1'b1, DMS_IRQ_STAT_OFS, 32'h1);
        `CHK("irq cleared", 1'b0, irq)
        bus(1'b0, DMS_IRQ_STAT_OFS, 32'h0);
        `CHK("irq left", 32'h2, q)
        bus(1'b1, DMS_IRQ_STAT_OFS, 32'h2);
    endtask

    task automatic test_quiet_busy;
        int f0;
        for (int k = 0; k < 12; k++)
            bus(1'b1, (k < 4) ? DMS_MOD_STATE_OFS + 8'(4 * k) : DMS_CHAN_OFS
                + 8'(4 * (k - 4)), 32'h0);
        slow <= 1'b0;
        put4(8'hA5);
        repeat (16)
            exp_q.push_back(10'h000);
        f0 = snk_u.frames;
        bus(1'b1, DMS_CTRL_OFS, 32'h0000A501);
        bus(1'b1, DMS_CTRL_OFS, 32'h0000A501);
        bus(1'b0, DMS_STATUS_OFS, 32'h0);
        `CHK("busy", 1'b1, q[0])
        check_frame(f0);
        repeat (40)
            @(posedge core_clk);
        `CHK("one frame", f0 + 1, snk_u.frames)
        `CHK("no extra", 0, snk_u.got.size())
        bus(1'b0, DMS_IRQ_STAT_OFS, 32'h0);
        `CHK("quiet stat", 32'h1, q)
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever
            #4 core_clk = ~core_clk;
    end

    initial
    begin
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        slow = 1'b0;
        miscompares = 0;
        tests_run = 0;
        repeat (6)
            @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        test_regs();
        test_full_frame();
        test_quiet_busy();
        tally_and_finish();
    end
endmodule

`default_nettype wire
